// ===== design/sal_regs.sv
`timescale 1ns/10ps
`include "sal_map.svh"

// Overview of operation
// - ch3 conversions checked against critical limit
// - ch3 averages checked against warning limit
// - ch3 limits bits 15-3, reset 7FF8h
// - ch2 warning limit in bits 15-3
// - total sums only selected channels' conversions
// - total refreshed once per full cycle
// - total read-only, sign 15, reset zero
// - total and its limit are twos-complement
// - total compared to limit each cycle
// - total limit bits 15-1, reset 7FFEh
// - config register steers both alert outputs
// - reading config register clears critical, warning and total flags
// - writing config register keeps alert flags
// - config register layout, reset 0002h
// - latch bits: 0 transparent, 1 latched
// - channel over critical sets flag, alert
// - total over limit sets flag, alert
// - select bit includes channel in total
module sal_regs
(
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire sal_pkg::sal_addr_t  regAddr,
  input  wire logic                regWrEn,
  input  wire logic                regRdEn,
  input  wire sal_pkg::sal_word_t  regWrData,
  output sal_pkg::sal_word_t       regRdData,
  input  wire logic                shuntValid,
  input  wire sal_pkg::sal_chan_t  shuntChannel,
  input  wire sal_pkg::sal_word_t  shuntValue,
  input  wire logic                avgValid,
  input  wire sal_pkg::sal_chan_t  avgChannel,
  input  wire sal_pkg::sal_word_t  avgValue,
  input  wire logic                cycleDone,
  input  wire logic                configWrite,
  input  wire logic                powerValidLevel,
  input  wire logic                timingAlertEvent,
  input  wire logic                conversionDone,
  input  wire sal_pkg::sal_word_t  ch1CritLimit,
  input  wire sal_pkg::sal_word_t  ch2CritLimit,
  input  wire sal_pkg::sal_word_t  ch1WarnLimit,
  output logic                     alertCritical,
  output logic                     alertWarning
);
  import sal_pkg::*;

  localparam sal_state_t RST_STATE = '{
    ch2WarnLimit:    `SAL_RST_LIMIT,
    ch3CritLimit:    `SAL_RST_LIMIT,
    ch3WarnLimit:    `SAL_RST_LIMIT,
    totalLimit:      `SAL_RST_TOTAL_LIMIT,
    totalValue:      `SAL_RST_TOTAL,
    timingAlertFlag: 1'(`SAL_RST_ALERT_CFG >> `SAL_BIT_TCF),
    default:         '0
  };

  sal_state_t       s;
  sal_state_t       next_s;
  logic [2:0][15:0] critLimits;
  logic [2:0][15:0] warnLimits;
  logic [2:0]       critExceed;
  logic [2:0]       warnExceed;
  logic [2:0]       critSeen;
  logic [2:0]       warnSeen;
  logic [2:0]       critHit;
  logic [2:0]       warnHit;
  logic             totalExceed;
  logic             readHit;
  sal_word_t        addend;
  sal_word_t        sumNow;
  sal_word_t        totalNext;
  sal_word_t        alertWord;

  // ----------------------------------------------------------------
  // per-channel limit comparators
  // ----------------------------------------------------------------
  assign critLimits = {s.ch3CritLimit, ch2CritLimit, ch1CritLimit};
  assign warnLimits = {s.ch3WarnLimit, s.ch2WarnLimit, ch1WarnLimit};

  for (genvar g = 0; g < 3; g++)
  begin : gen_chan
    sal_limit_cmp
    #(
      .W        (16),
      .RSV_BITS (`SAL_LIMIT_RSV_BITS)
    )
    u_crit
    (
      .value  (shuntValue),
      .limit  (critLimits[g]),
      .exceed (critExceed[g])
    );

    sal_limit_cmp
    #(
      .W        (16),
      .RSV_BITS (`SAL_LIMIT_RSV_BITS)
    )
    u_warn
    (
      .value  (avgValue),
      .limit  (warnLimits[g]),
      .exceed (warnExceed[g])
    );

    assign critSeen[g] = shuntValid && (shuntChannel == 2'(g));
    assign warnSeen[g] = avgValid && (avgChannel == 2'(g));
    assign critHit[g]  = critSeen[g] && critExceed[g];
    assign warnHit[g]  = warnSeen[g] && warnExceed[g];
  end

  // ----------------------------------------------------------------
  // running total of selected single conversions
  // ----------------------------------------------------------------
  assign addend = (|(critSeen & s.totalChannelSelect)) ?
                  {{3{shuntValue[15]}}, shuntValue[15:3]} : '0;
  assign sumNow    = s.accum + addend;
  assign totalNext = {sumNow[14:0], 1'b0};

  sal_limit_cmp
  #(
    .W        (16),
    .RSV_BITS (`SAL_TOTAL_RSV_BITS)
  )
  u_total
  (
    .value  (totalNext),
    .limit  (s.totalLimit),
    .exceed (totalExceed)
  );

  // ----------------------------------------------------------------
  // register read view
  // ----------------------------------------------------------------
  assign readHit   = regRdEn && (regAddr == `SAL_OFF_ALERT_CFG);
  assign alertWord = {s.rsvTop, sal_rev3(s.totalChannelSelect),
                      s.warnLatchOn, s.criticalLatchOn,
                      sal_rev3(s.criticalChannelFlags), s.totalAlertFlag,
                      sal_rev3(s.warningChannelFlags), s.powerGoodFlag,
                      s.timingAlertFlag, s.conversionDoneFlag};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    // host writes
    if (regWrEn)
    begin
      case (regAddr)
        `SAL_OFF_CH2_WARN:
          next_s.ch2WarnLimit = regWrData & `SAL_MASK_LIMIT;
        `SAL_OFF_CH3_CRIT:
          next_s.ch3CritLimit = regWrData & `SAL_MASK_LIMIT;
        `SAL_OFF_CH3_WARN:
          next_s.ch3WarnLimit = regWrData & `SAL_MASK_LIMIT;
        `SAL_OFF_TOTAL_LIMIT:
          next_s.totalLimit = regWrData & `SAL_MASK_TOTAL;
        `SAL_OFF_ALERT_CFG:
        begin
          // flags are not writable
          next_s.rsvTop = regWrData[`SAL_BIT_RSV];
          next_s.totalChannelSelect =
            sal_rev3(regWrData[`SAL_BIT_SEL_HI:`SAL_BIT_SEL_LO]);
          next_s.warnLatchOn = regWrData[`SAL_BIT_WARN_LATCH];
          next_s.criticalLatchOn = regWrData[`SAL_BIT_CRIT_LATCH];
        end
        default:
          next_s.rsvTop = s.rsvTop; // total register is read-only
      endcase
    end
    // host reads, unmapped offsets read zero
    if (regRdEn)
    begin
      case (regAddr)
        `SAL_OFF_CH2_WARN:    next_s.rdData = s.ch2WarnLimit;
        `SAL_OFF_CH3_CRIT:    next_s.rdData = s.ch3CritLimit;
        `SAL_OFF_CH3_WARN:    next_s.rdData = s.ch3WarnLimit;
        `SAL_OFF_TOTAL:       next_s.rdData = s.totalValue;
        `SAL_OFF_TOTAL_LIMIT: next_s.rdData = s.totalLimit;
        `SAL_OFF_ALERT_CFG:   next_s.rdData = alertWord;
        default:              next_s.rdData = '0;
      endcase
    end
    // present over-limit state per channel
    for (int c = 0; c < 3; c++)
    begin
      if (critSeen[c])
        next_s.critOver[c] = critExceed[c];
      if (warnSeen[c])
        next_s.warnOver[c] = warnExceed[c];
    end
    // sticky flags (powerGoodFlag follows powerValidLevel), a set in the read cycle survives
    next_s.criticalChannelFlags =
      (s.criticalChannelFlags & ~{3{readHit}}) | critHit;
    next_s.warningChannelFlags =
      (s.warningChannelFlags & ~{3{readHit}}) | warnHit;
    next_s.totalAlertFlag = s.totalAlertFlag & ~readHit;
    next_s.conversionDoneFlag =
      (s.conversionDoneFlag & ~(readHit | configWrite)) | conversionDone;
    next_s.powerGoodFlag   = powerValidLevel;
    next_s.timingAlertFlag = s.timingAlertFlag | timingAlertEvent;
    // total and its compare once per full cycle
    next_s.accum = sumNow;
    if (cycleDone)
    begin
      next_s.totalValue = totalNext;
      next_s.accum      = '0;
      next_s.totalOver  = totalExceed;
      if (totalExceed)
        next_s.totalAlertFlag = 1'b1;
    end
    // alert outputs
    next_s.alertCrit = s.criticalLatchOn ?
      (|next_s.criticalChannelFlags) | next_s.totalAlertFlag :
      (|next_s.critOver) | next_s.totalOver;
    next_s.alertWarn = s.warnLatchOn ?
      (|next_s.warningChannelFlags) : (|next_s.warnOver);
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      s <= RST_STATE;
    else
      s <= next_s;
  end

  assign regRdData     = s.rdData;
  assign alertCritical = s.alertCrit;
  assign alertWarning  = s.alertWarn;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  AST_CH3_CRIT_FLAG: assert property (
    shuntValid && shuntChannel == 2'd2 &&
    $signed(shuntValue & `SAL_MASK_LIMIT) > $signed(s.ch3CritLimit)
    |=> s.criticalChannelFlags[2] && alertCritical)
    else $error("ch3 critical overrun not flagged");

  AST_CH3_WARN_FLAG: assert property (
    avgValid && avgChannel == 2'd2 &&
    $signed(avgValue & `SAL_MASK_LIMIT) > $signed(s.ch3WarnLimit)
    |=> s.warningChannelFlags[2] && alertWarning)
    else $error("ch3 warning overrun not flagged");

  AST_CH3_LIMIT_WRITE: assert property (
    regWrEn && regAddr == `SAL_OFF_CH3_CRIT
    |=> s.ch3CritLimit == ($past(regWrData) & `SAL_MASK_LIMIT))
    else $error("ch3 critical limit write wrong");

  AST_CH2_READBACK: assert property (
    regWrEn && regAddr == `SAL_OFF_CH2_WARN ##1 !regWrEn ##1
    regRdEn && regAddr == `SAL_OFF_CH2_WARN && !regWrEn
    |=> regRdData == ($past(regWrData, 3) & `SAL_MASK_LIMIT))
    else $error("ch2 warning limit readback wrong");

  AST_TOTAL_HOLD: assert property (
    !cycleDone |=> $stable(s.totalValue))
    else $error("total changed outside cycle end");

  AST_TOTAL_LSB: assert property (
    s.totalValue[0] == 1'b0 && s.totalLimit[0] == 1'b0)
    else $error("total reserved bit set");

  AST_TOTAL_ALERT: assert property (
    cycleDone && $signed(totalNext) > $signed(s.totalLimit)
    |=> s.totalAlertFlag && alertCritical)
    else $error("total overrun not alerted");

  AST_READ_CLEAR: assert property (
    readHit && !shuntValid && !avgValid && !cycleDone
    |=> s.criticalChannelFlags == 3'h0 && s.warningChannelFlags == 3'h0
        && !s.totalAlertFlag)
    else $error("flags not cleared by read");

  AST_WRITE_KEEP: assert property (
    regWrEn && regAddr == `SAL_OFF_ALERT_CFG && !regRdEn
    |=> (s.criticalChannelFlags & $past(s.criticalChannelFlags))
        == $past(s.criticalChannelFlags)
        && (s.warningChannelFlags & $past(s.warningChannelFlags))
        == $past(s.warningChannelFlags)
        && (s.totalAlertFlag || !$past(s.totalAlertFlag)))
    else $error("flags lost on write");

  AST_LATCH_HOLD: assert property (
    s.criticalLatchOn && (|s.criticalChannelFlags) && !readHit
    && !regWrEn ##1 !readHit |-> alertCritical [*2])
    else $error("latched critical alert dropped");

  AST_SEL_EXCLUDE: assert property (
    !(|(critSeen & s.totalChannelSelect)) && !cycleDone
    |=> $stable(s.accum))
    else $error("unselected channel entered total");

  COV_CRIT_ALERT: cover property (critHit[2] ##1 alertCritical);
  COV_TOTAL_ALERT: cover property (cycleDone && totalExceed);
  COV_READ_CLEAR: cover property (readHit && (|s.warningChannelFlags));
  COV_LATCHED: cover property (s.warnLatchOn && alertWarning && readHit);

endmodule

// ===== design/sal_map.svh
`ifndef SAL_MAP_SVH
`define SAL_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SAL_OFF_CH2_WARN     8'h0A
`define SAL_OFF_CH3_CRIT     8'h0B
`define SAL_OFF_CH3_WARN     8'h0C
`define SAL_OFF_TOTAL        8'h0D
`define SAL_OFF_TOTAL_LIMIT  8'h0E
`define SAL_OFF_ALERT_CFG    8'h0F

// ----------------------------------------------------------------
// reset values and field masks
// ----------------------------------------------------------------
`define SAL_RST_LIMIT        16'h7FF8
`define SAL_RST_TOTAL_LIMIT  16'h7FFE
`define SAL_RST_TOTAL        16'h0000
`define SAL_RST_ALERT_CFG    16'h0002
`define SAL_MASK_LIMIT       16'hFFF8
`define SAL_MASK_TOTAL       16'hFFFE

// ----------------------------------------------------------------
// alert_select_and_flags field positions
// ----------------------------------------------------------------
`define SAL_BIT_RSV          15
`define SAL_BIT_SEL_HI       14
`define SAL_BIT_SEL_LO       12
`define SAL_BIT_WARN_LATCH   11
`define SAL_BIT_CRIT_LATCH   10
`define SAL_BIT_CF_HI        9
`define SAL_BIT_CF_LO        7
`define SAL_BIT_SF           6
`define SAL_BIT_WF_HI        5
`define SAL_BIT_WF_LO        3
`define SAL_BIT_PVF          2
`define SAL_BIT_TCF          1
`define SAL_BIT_CONVERSION_DONE_FLAG         0

// ----------------------------------------------------------------
// data alignment
// ----------------------------------------------------------------
`define SAL_LIMIT_RSV_BITS   3
`define SAL_TOTAL_RSV_BITS   1

`endif

// ===== design/sal_pkg.sv
package sal_pkg;

  typedef logic [15:0] sal_word_t;
  typedef logic [7:0]  sal_addr_t;
  typedef logic [1:0]  sal_chan_t;

  // index 0 is channel 1 in every 3-bit vector
  typedef struct packed {
    sal_word_t  ch2WarnLimit;
    sal_word_t  ch3CritLimit;
    sal_word_t  ch3WarnLimit;
    sal_word_t  totalLimit;
    sal_word_t  totalValue;
    sal_word_t  accum;
    logic       rsvTop;
    logic [2:0] totalChannelSelect;
    logic       warnLatchOn;
    logic       criticalLatchOn;
    logic [2:0] criticalChannelFlags;
    logic       totalAlertFlag;
    logic [2:0] warningChannelFlags;
    logic       powerGoodFlag;
    logic       timingAlertFlag;
    logic       conversionDoneFlag;
    logic [2:0] critOver;
    logic [2:0] warnOver;
    logic       totalOver;
    sal_word_t  rdData;
    logic       alertCrit;
    logic       alertWarn;
  } sal_state_t;

  // channel 1 sits in the highest bit of each register field
  function automatic logic [2:0] sal_rev3(input logic [2:0] v);
    sal_rev3 = {v[0], v[1], v[2]};
  endfunction

endpackage

// ===== design/sal_limit_cmp.sv
`timescale 1ns/10ps
`include "sal_map.svh"

module sal_limit_cmp
#(
  parameter int W        = 16,
  parameter int RSV_BITS = `SAL_LIMIT_RSV_BITS
)
(
  input  wire logic [W-1:0] value,
  input  wire logic [W-1:0] limit,
  output logic              exceed
);

  logic [W-1:0] valueAligned;
  logic [W-1:0] limitAligned;

  // ----------------------------------------------------------------
  // signed strict compare on equal bit weighting
  // ----------------------------------------------------------------
  assign valueAligned = {value[W-1:RSV_BITS], {RSV_BITS{1'b0}}};
  assign limitAligned = {limit[W-1:RSV_BITS], {RSV_BITS{1'b0}}};
  assign exceed = $signed(valueAligned) > $signed(limitAligned);

endmodule

// ===== tb/sal_meas_model.sv
`timescale 1ns/10ps

module sal_meas_model
(
  input  wire logic          clock,
  output logic               shuntValid,
  output sal_pkg::sal_chan_t shuntChannel,
  output sal_pkg::sal_word_t shuntValue,
  output logic               avgValid,
  output sal_pkg::sal_chan_t avgChannel,
  output sal_pkg::sal_word_t avgValue,
  output logic               cycleDone
);
  import sal_pkg::*;

  initial
  begin
    shuntValid   = 1'b0;
    shuntChannel = 2'd3;
    shuntValue   = 16'h5a5a;
    avgValid     = 1'b0;
    avgChannel   = 2'd3;
    avgValue     = 16'ha5a5;
    cycleDone    = 1'b0;
  end

  // ----------------------------------------
  // conversions, data scrambled when idle
  // ----------------------------------------
  task automatic shunt(input sal_chan_t ch, input sal_word_t v);
    @(negedge clock);
    shuntValid   = 1'b1;
    shuntChannel = ch;
    shuntValue   = v;
    @(negedge clock);
    shuntValid   = 1'b0;
    shuntValue   = ~v;
  endtask

  task automatic avg(input sal_chan_t ch, input sal_word_t v);
    @(negedge clock);
    avgValid   = 1'b1;
    avgChannel = ch;
    avgValue   = v;
    @(negedge clock);
    avgValid   = 1'b0;
    avgValue   = ~v;
  endtask

  task automatic done_pulse();
    @(negedge clock);
    cycleDone = 1'b1;
    @(negedge clock);
    cycleDone = 1'b0;
  endtask
endmodule

// ===== tb/test_shunt_sum_alert_limits.sv
`timescale 1ns/10ps

module test_shunt_sum_alert_limits;
  import sal_pkg::*;

  typedef struct {sal_word_t exp; string what;} sal_note_t;

  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  sal_addr_t   regAddr = 8'h00;
  logic        regWrEn = 1'b0;
  logic        regRdEn = 1'b0;
  sal_word_t   regWrData = 16'h0000;
  sal_word_t   regRdData;
  logic        shuntValid, avgValid, cycleDone;
  sal_chan_t   shuntChannel, avgChannel;
  sal_word_t   shuntValue, avgValue;
  logic        configWrite = 1'b0;
  logic        powerValidLevel = 1'b0;
  logic        timingAlertEvent = 1'b0;
  logic        conversionDone = 1'b0;
  sal_word_t   ch1CritLimit = 16'h7ff8;
  sal_word_t   ch2CritLimit = 16'h7ff8;
  sal_word_t   ch1WarnLimit = 16'h7ff8;
  logic        alertCritical, alertWarning;
  logic        rdSeen = 1'b0;
  int          errTotal = 0;
  int          numChecks = 0;
  sal_note_t   notes[$];
  sal_word_t   rstVal[7] = '{16'h7ff8, 16'h7ff8, 16'h7ff8, 16'h0000,
                             16'h7ffe, 16'h0002, 16'h0000};

  always #50 clock = ~clock;

  sal_regs i_sal_regs (.clock, .rst_n, .regAddr, .regWrEn, .regRdEn,
    .regWrData, .regRdData, .shuntValid, .shuntChannel, .shuntValue,
    .avgValid, .avgChannel, .avgValue, .cycleDone, .configWrite,
    .powerValidLevel, .timingAlertEvent, .conversionDone, .ch1CritLimit,
    .ch2CritLimit, .ch1WarnLimit, .alertCritical, .alertWarning);

  sal_meas_model i_sal_meas_model (.clock, .shuntValid, .shuntChannel,
    .shuntValue, .avgValid, .avgChannel, .avgValue, .cycleDone);

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string what, input sal_word_t e,
                       input sal_word_t got);
    numChecks++;
    if (got !== e)
    begin
      errTotal++;
      $display("mismatch %s expected %h seen %h", what, e, got);
    end
  endtask

  task automatic finalReport();
    $display("checks %0d mismatches %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input sal_addr_t a, input sal_word_t d);
    @(negedge clock);
    regWrEn   = 1'b1;
    regAddr   = a;
    regWrData = d;
    @(negedge clock);
    regWrEn   = 1'b0;
    regWrData = ~d;
  endtask

  // note the expectation, the watcher compares it
  task automatic rd(input sal_addr_t a, input sal_word_t e,
                    input string what);
    sal_note_t n;
    n.exp  = e;
    n.what = what;
    notes.push_back(n);
    @(negedge clock);
    regRdEn = 1'b1;
    regAddr = a;
    @(negedge clock);
    regRdEn = 1'b0;
  endtask

  always @(posedge clock)
    rdSeen <= regRdEn;

  always @(negedge clock)
  begin
    sal_note_t n;
    if (rdSeen)
    begin
      if (notes.size() == 0)
        check("unexpected read", 16'h0000, 16'hffff);
      else
      begin
        n = notes.pop_front();
        check(n.what, n.exp, regRdData);
      end
    end
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    check("timeout", 16'h0000, 16'hffff);
    finalReport();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    sal_word_t d;
    sal_word_t v1;
    sal_word_t v3;
    sal_word_t expT;
    void'($urandom(32'h6c3d_69f1));
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    for (int i = 0; i < 7; i++)
      rd(8'h0a + 8'(i), rstVal[i], "reset value");
    for (int i = 0; i < 3; i++)
    begin
      d = 16'($urandom);
      wr(8'h0a + 8'(i), d);
      rd(8'h0a + 8'(i), d & 16'hfff8, "limit readback");
    end
    d = 16'($urandom);
    wr(8'h0e, d);
    rd(8'h0e, d & 16'hfffe, "total limit readback");
    wr(8'h0d, d);
    rd(8'h0d, 16'h0000, "total write ignored");
    // fast channel-3 compare, transparent
    wr(8'h0b, 16'h0100);
    i_sal_meas_model.shunt(2'd2, 16'h0108);
    check("alertCritical", 16'h0001, {15'h0000, alertCritical});
    rd(8'h0f, 16'h0082, "critical flag");
    i_sal_meas_model.shunt(2'd2, 16'h8008);
    check("alertCritical", 16'h0000, {15'h0000, alertCritical});
    i_sal_meas_model.shunt(2'd2, 16'h0100);
    check("alertCritical", 16'h0000, {15'h0000, alertCritical});
    rd(8'h0f, 16'h0002, "flags before setup");
    // averaged channel-3 compare, latched
    wr(8'h0f, 16'h0800);
    wr(8'h0c, 16'h0200);
    i_sal_meas_model.avg(2'd2, 16'h0208);
    check("alertWarning", 16'h0001, {15'h0000, alertWarning});
    i_sal_meas_model.avg(2'd2, 16'h0100);
    check("alertWarning", 16'h0001, {15'h0000, alertWarning});
    wr(8'h0f, 16'h8800);
    rd(8'h0f, 16'h880a, "flags kept by write");
    rd(8'h0f, 16'h8802, "flags cleared by read");
    check("alertWarning", 16'h0000, {15'h0000, alertWarning});
    // latched critical, transparent warning
    wr(8'h0f, 16'h0400);
    i_sal_meas_model.avg(2'd2, 16'h0208);
    check("alertWarning", 16'h0001, {15'h0000, alertWarning});
    i_sal_meas_model.avg(2'd2, 16'h0100);
    check("alertWarning", 16'h0000, {15'h0000, alertWarning});
    i_sal_meas_model.shunt(2'd2, 16'h0108);
    i_sal_meas_model.shunt(2'd2, 16'h0100);
    check("alertCritical", 16'h0001, {15'h0000, alertCritical});
    rd(8'h0f, 16'h048a, "latched flags");
    check("alertCritical", 16'h0000, {15'h0000, alertCritical});
    // total of channels 1 and 3 only
    wr(8'h0f, 16'h5000);
    wr(8'h0e, 16'h7ffe);
    i_sal_meas_model.done_pulse();
    v1   = 16'($urandom) & 16'h3ff8;
    v3   = 16'hff80;
    expT = 16'((($signed(v1) >>> 3) + ($signed(v3) >>> 3)) << 1);
    i_sal_meas_model.shunt(2'd0, v1);
    i_sal_meas_model.shunt(2'd1, 16'h1000);
    i_sal_meas_model.shunt(2'd2, v3);
    rd(8'h0d, 16'h0000, "total before cycle end");
    wr(8'h0e, expT - 16'h0002);
    check("alertCritical", 16'h0000, {15'h0000, alertCritical});
    i_sal_meas_model.done_pulse();
    rd(8'h0d, expT, "total");
    check("alertCritical", 16'h0001, {15'h0000, alertCritical});
    rd(8'h0f, 16'h5042, "total flag");
    // status flags
    powerValidLevel = 1'b1;
    @(negedge clock);
    conversionDone = 1'b1;
    @(negedge clock);
    conversionDone = 1'b0;
    rd(8'h0f, 16'h5007, "status flags");
    rd(8'h0f, 16'h5006, "ready flag cleared");
    repeat (2) @(negedge clock);
    if (notes.size() != 0)
      check("pending reads", 16'h0000, 16'(notes.size()));
    finalReport();
  end
endmodule
